/* pkg/lan_queue_boundary_pkg.sv */
package lan_queue_boundary_pkg;

  // bus geometry
  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_STRB_W = 4;
  localparam int INDEX_W = 10;
  localparam int INDEX_LSB = 2;

  // register geometry
  localparam int REG_W = 16;
  localparam int FIELD_W = 10;
  localparam int FIELD_LSB = 0;
  localparam int PTR_RESET_BIT = 10;
  localparam int LANE_W = 8;
  localparam int LANE_COUNT = 2;

  // each field step is one region of 32,768 bytes
  localparam int GRAIN_BYTES = 32768;
  localparam int GRAIN_SHIFT = $clog2(GRAIN_BYTES);
  localparam int BYTE_ADDR_W = FIELD_W + GRAIN_SHIFT;

  localparam logic [REG_W-1:0] REG_RESET_VALUE = 16'h0000;
  localparam logic [FIELD_W-1:0] FIELD_RESET_VALUE = 10'h000;

  // queue populations; first start queue is 12, first end queue is 1
  localparam int START_COUNT = 5;
  localparam int END_COUNT = 8;
  localparam int REG_COUNT = START_COUNT + END_COUNT;
  localparam int FIRST_START_QUEUE = 12;
  localparam int FIRST_END_QUEUE = 1;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [INDEX_W-1:0] LAN_QUEUE12_START = 10'h116;
  localparam logic [INDEX_W-1:0] LAN_QUEUE13_START = 10'h118;
  localparam logic [INDEX_W-1:0] LAN_QUEUE14_START = 10'h11a;
  localparam logic [INDEX_W-1:0] LAN_QUEUE15_START = 10'h11c;
  localparam logic [INDEX_W-1:0] LAN_QUEUE16_START = 10'h11e;
  localparam logic [INDEX_W-1:0] LAN_QUEUE1_END = 10'h120;
  localparam logic [INDEX_W-1:0] LAN_QUEUE2_END = 10'h122;
  localparam logic [INDEX_W-1:0] LAN_QUEUE3_END = 10'h124;
  localparam logic [INDEX_W-1:0] LAN_QUEUE4_END = 10'h126;
  localparam logic [INDEX_W-1:0] LAN_QUEUE5_END = 10'h128;
  localparam logic [INDEX_W-1:0] LAN_QUEUE6_END = 10'h12a;
  localparam logic [INDEX_W-1:0] LAN_QUEUE7_END = 10'h12c;
  localparam logic [INDEX_W-1:0] LAN_QUEUE8_END = 10'h12e;

  // register table in slot order: start registers first, then end registers
  localparam logic [INDEX_W-1:0] REG_INDEX [REG_COUNT] = '{
    LAN_QUEUE12_START, LAN_QUEUE13_START, LAN_QUEUE14_START,
    LAN_QUEUE15_START, LAN_QUEUE16_START,
    LAN_QUEUE1_END, LAN_QUEUE2_END, LAN_QUEUE3_END, LAN_QUEUE4_END,
    LAN_QUEUE5_END, LAN_QUEUE6_END, LAN_QUEUE7_END, LAN_QUEUE8_END
  };

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'h1,
    WR_RESPOND = 2'h2
  } write_state_t;

  typedef enum logic [1:0] {
    RD_ACCEPT = 2'h1,
    RD_RESPOND = 2'h2
  } read_state_t;

  typedef struct packed {
    logic [INDEX_W-1:0] index;
  } addr_beat_t;

  typedef struct packed {
    logic [REG_W-1:0] data;
    logic [LANE_COUNT-1:0] strb;
  } data_beat_t;

endpackage

/* design/queue_boundary_reg.sv */
`timescale 1ns/1ps
`default_nettype none

module queue_boundary_reg
  import lan_queue_boundary_pkg::*;
#(
  parameter bit HAS_PTR_RESET = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic write_en,
  input wire data_beat_t beat,
  output logic [FIELD_W-1:0] field,
  output logic ptr_reset
);

  logic [FIELD_W-1:0] next_field;
  logic next_ptr_reset;

  always_comb begin
    next_field = field;
    next_ptr_reset = 1'b0;
    if (write_en) begin
      // low lane holds bits 7..0, high lane bits 15..8
      if (beat.strb[0]) begin
        next_field[LANE_W-1:0] = beat.data[LANE_W-1:0];
      end
      if (beat.strb[1]) begin
        next_field[FIELD_W-1:LANE_W] = beat.data[FIELD_W-1:LANE_W];
        // a zero here leaves the pointers alone, so the start can be rewritten
        next_ptr_reset = HAS_PTR_RESET && beat.data[PTR_RESET_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      field <= FIELD_RESET_VALUE;
      ptr_reset <= 1'b0;
    end else begin
      field <= next_field;
      // one-cycle pulse ends by itself; nothing is stored for software to clear
      ptr_reset <= next_ptr_reset;
    end
  end

endmodule

`default_nettype wire

/* design/lan_queue_boundary_registers.sv */
`timescale 1ns/1ps
`default_nettype none

module lan_queue_boundary_registers
  import lan_queue_boundary_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [AXI_STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [START_COUNT-1:0][FIELD_W-1:0] lan_queue_start_field,
  output logic [START_COUNT-1:0][BYTE_ADDR_W-1:0] lan_queue_start_byte_addr,
  output logic [START_COUNT-1:0] lan_queue_pointer_reset,
  output logic [END_COUNT-1:0][FIELD_W-1:0] lan_queue_end_field,
  output logic [END_COUNT-1:0][BYTE_ADDR_W-1:0] lan_queue_end_byte_addr
);

  localparam logic [GRAIN_SHIFT-1:0] GRAIN_ZEROS = '0;
  localparam logic [REG_W-FIELD_W-1:0] UNUSED_ZEROS = '0;
  localparam logic [AXI_DATA_W-REG_W-1:0] UPPER_ZEROS = '0;

  // write channel state
  write_state_t write_state;
  write_state_t next_write_state;
  logic aw_full;
  logic next_aw_full;
  logic w_full;
  logic next_w_full;
  addr_beat_t aw_beat;
  addr_beat_t next_aw_beat;
  data_beat_t w_beat;
  data_beat_t next_w_beat;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;

  // read channel state
  read_state_t read_state;
  read_state_t next_read_state;
  logic next_arready;
  logic next_rvalid;
  logic [1:0] next_rresp;
  logic [AXI_DATA_W-1:0] next_rdata;

  // register slots
  logic [REG_COUNT-1:0] slot_write;
  logic [REG_COUNT-1:0][FIELD_W-1:0] slot_field;
  logic [REG_COUNT-1:0] slot_ptr_reset;
  logic write_fire;
  logic write_hit;
  logic [REG_COUNT-1:0] write_match;
  logic read_hit;
  logic [REG_W-1:0] read_value;
  addr_beat_t ar_beat;

  assign ar_beat.index = s_axi_araddr[INDEX_LSB +: INDEX_W];

  // both beats held and no response pending: the write lands now
  assign write_fire = aw_full && w_full && (write_state == WR_COLLECT);

  always_comb begin
    write_match = '0;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (aw_beat.index == REG_INDEX[i]) begin
        write_match[i] = 1'b1;
      end
    end
  end

  assign write_hit = |write_match;
  assign slot_write = write_fire ? write_match : '0;

  // write channel: address and data accepted in either order
  always_comb begin
    next_write_state = write_state;
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_aw_beat = aw_beat;
    next_w_beat = w_beat;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_beat.index = s_axi_awaddr[INDEX_LSB +: INDEX_W];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_beat.data = s_axi_wdata[REG_W-1:0];
      next_w_beat.strb = s_axi_wstrb[LANE_COUNT-1:0];
    end
    case (write_state)
      WR_COLLECT: begin
        if (write_fire) begin
          next_write_state = WR_RESPOND;
          next_bvalid = 1'b1;
          // unmapped writes change nothing and report an error
          next_bresp = write_hit ? RESP_OKAY : RESP_SLVERR;
        end
      end
      WR_RESPOND: begin
        if (s_axi_bready) begin
          next_write_state = WR_COLLECT;
          next_bvalid = 1'b0;
          next_bresp = RESP_OKAY;
          next_aw_full = 1'b0;
          next_w_full = 1'b0;
        end
      end
      default: begin
        next_write_state = WR_COLLECT;
        next_bvalid = 1'b0;
        next_aw_full = 1'b0;
        next_w_full = 1'b0;
      end
    endcase
    // ready is registered, so it is computed from the next holding state
    next_awready = !next_aw_full;
    next_wready = !next_w_full;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_state <= WR_COLLECT;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_beat <= '0;
      w_beat <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      write_state <= next_write_state;
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_beat <= next_aw_beat;
      w_beat <= next_w_beat;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  // read decode; the pointer reset bit is momentary and always reads zero
  always_comb begin
    read_hit = 1'b0;
    read_value = REG_RESET_VALUE;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (ar_beat.index == REG_INDEX[i]) begin
        read_hit = 1'b1;
        read_value = {UNUSED_ZEROS, slot_field[i]};
      end
    end
  end

  always_comb begin
    next_read_state = read_state;
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    case (read_state)
      RD_ACCEPT: begin
        if (s_axi_arvalid && s_axi_arready) begin
          next_read_state = RD_RESPOND;
          next_arready = 1'b0;
          next_rvalid = 1'b1;
          if (read_hit) begin
            next_rdata = {UPPER_ZEROS, read_value};
            next_rresp = RESP_OKAY;
          end else begin
            next_rdata = '0;
            next_rresp = RESP_SLVERR;
          end
        end else begin
          next_arready = 1'b1;
        end
      end
      RD_RESPOND: begin
        if (s_axi_rready) begin
          next_read_state = RD_ACCEPT;
          next_arready = 1'b1;
          next_rvalid = 1'b0;
          next_rresp = RESP_OKAY;
          next_rdata = '0;
        end
      end
      default: begin
        next_read_state = RD_ACCEPT;
        next_arready = 1'b0;
        next_rvalid = 1'b0;
        next_rresp = RESP_OKAY;
        next_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_state <= RD_ACCEPT;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
    end else begin
      read_state <= next_read_state;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // one slot per register; only start slots carry a pointer reset
  for (genvar g = 0; g < REG_COUNT; g++) begin : g_slot
    queue_boundary_reg #(
      .HAS_PTR_RESET(g < START_COUNT)
    ) u_reg (
      .aclk(aclk),
      .aresetn(aresetn),
      .write_en(slot_write[g]),
      .beat(w_beat),
      .field(slot_field[g]),
      .ptr_reset(slot_ptr_reset[g])
    );
    if (g < START_COUNT) begin : g_start
      assign lan_queue_start_field[g] = slot_field[g];
      assign lan_queue_start_byte_addr[g] = {slot_field[g], GRAIN_ZEROS};
      assign lan_queue_pointer_reset[g] = slot_ptr_reset[g];
    end else begin : g_end
      assign lan_queue_end_field[g-START_COUNT] = slot_field[g];
      assign lan_queue_end_byte_addr[g-START_COUNT] = {slot_field[g], GRAIN_ZEROS};
    end
  end

endmodule

`default_nettype wire

/* test/lan_queue_boundary_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module lan_queue_boundary_chk
  import lan_queue_boundary_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
  input wire logic [START_COUNT-1:0][FIELD_W-1:0] lan_queue_start_field,
  input wire logic [START_COUNT-1:0][BYTE_ADDR_W-1:0] lan_queue_start_byte_addr,
  input wire logic [START_COUNT-1:0] lan_queue_pointer_reset,
  input wire logic [END_COUNT-1:0][FIELD_W-1:0] lan_queue_end_field,
  input wire logic [END_COUNT-1:0][BYTE_ADDR_W-1:0] lan_queue_end_byte_addr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic scaled_ok;
  always_comb begin
    scaled_ok = 1'h1;
    for (int k = 0; k < START_COUNT; k++) begin
      if (lan_queue_start_byte_addr[k] != BYTE_ADDR_W'(lan_queue_start_field[k]) << GRAIN_SHIFT)
        scaled_ok = 1'h0;
    end
    for (int k = 0; k < END_COUNT; k++) begin
      if (lan_queue_end_byte_addr[k] != BYTE_ADDR_W'(lan_queue_end_field[k]) << GRAIN_SHIFT)
        scaled_ok = 1'h0;
    end
  end
  property p_scaled; scaled_ok; endproperty
  a_scaled: assert property (p_scaled) else $error("byte address not field times grain");
  property p_pulse_single; |lan_queue_pointer_reset |=> lan_queue_pointer_reset == '0; endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("pulse longer than one cycle");
  property p_pulse_write; |lan_queue_pointer_reset |-> $rose(s_axi_bvalid); endproperty
  a_pulse_write: assert property (p_pulse_write) else $error("pulse without a landing write");
  property p_pulse_onehot; $onehot0(lan_queue_pointer_reset); endproperty
  a_pulse_onehot: assert property (p_pulse_onehot) else $error("more than one queue pulsed");
  property p_start_hold; !$stable(lan_queue_start_field) |-> $rose(s_axi_bvalid); endproperty
  a_start_hold: assert property (p_start_hold) else $error("start field moved without write");
  property p_end_hold; !$stable(lan_queue_end_field) |-> $rose(s_axi_bvalid); endproperty
  a_end_hold: assert property (p_end_hold) else $error("end field moved without write");
  property p_rdata_clear; s_axi_rvalid |-> s_axi_rdata[AXI_DATA_W-1:FIELD_W] == '0; endproperty
  a_rdata_clear: assert property (p_rdata_clear) else $error("unused read bits not zero");
  property p_reset_clear;
    !$past(aresetn) |-> lan_queue_start_field == '0 && lan_queue_end_field == '0
      && lan_queue_pointer_reset == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
endmodule
bind lan_queue_boundary_registers lan_queue_boundary_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .lan_queue_start_field(lan_queue_start_field),
  .lan_queue_start_byte_addr(lan_queue_start_byte_addr),
  .lan_queue_pointer_reset(lan_queue_pointer_reset), .lan_queue_end_field(lan_queue_end_field),
  .lan_queue_end_byte_addr(lan_queue_end_byte_addr)
);
`default_nettype wire

/* test/lan_queue_boundary_registers_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module lan_queue_boundary_registers_bench
  import lan_queue_boundary_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [AXI_DATA_W-1:0] wdata, rdata, data;
  logic [AXI_STRB_W-1:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [START_COUNT-1:0][FIELD_W-1:0] sf;
  logic [START_COUNT-1:0][BYTE_ADDR_W-1:0] sb;
  logic [START_COUNT-1:0] pr, pulse;
  logic [END_COUNT-1:0][FIELD_W-1:0] ef;
  logic [END_COUNT-1:0][BYTE_ADDR_W-1:0] eb;
  logic [FIELD_W-1:0] v;
  int miscompares, n_checks;
  lan_queue_boundary_registers DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lan_queue_start_field(sf),
    .lan_queue_start_byte_addr(sb), .lan_queue_pointer_reset(pr), .lan_queue_end_field(ef),
    .lan_queue_end_byte_addr(eb));
  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end
  task wrap_up;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: response %h expected %h", $time, got, exp);
    end
  endtask
  // the bound only cuts a hang; the slave's latency is never assumed
  task wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      n++;
    end while (bvalid !== 1'h1 && n < 50);
    if (bvalid !== 1'h1) begin
      miscompares++;
      wrap_up;
    end
    resp = bresp;
    pulse = pr;
    bready <= 1'h0;
  endtask
  task rd(input logic [11:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      n++;
    end while (rvalid !== 1'h1 && n < 50);
    if (rvalid !== 1'h1) begin
      miscompares++;
      wrap_up;
    end
    data = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    miscompares = 0;
    n_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < REG_COUNT; i++) begin
      rd({REG_INDEX[i], 2'h0});
      chk_val(data, 32'h0000_0000);
      chk_resp(resp, RESP_OKAY);
    end
    for (int k = 0; k < START_COUNT; k++) begin
      v = 10'h2a5 + 10'(k * 37);
      wr({REG_INDEX[k], 2'h0}, {6'h01, v}, 4'hf);
      chk_resp(resp, RESP_OKAY);
      chk_val(32'(pulse), 32'h0000_0001 << k);
      chk_val(32'(sf[k]), 32'(v));
      chk_val(32'(sb[k]), 32'(v) * GRAIN_BYTES);
      rd({REG_INDEX[k], 2'h0});
      chk_val(data, 32'(v));
      chk_val(32'(pr), 32'h0000_0000);
      wr({REG_INDEX[k], 2'h0}, {6'h00, v}, 4'hf);
      chk_val(32'(pulse), 32'h0000_0000);
      chk_val(32'(sf[k]), 32'(v));
    end
    for (int k = 0; k < END_COUNT; k++) begin
      v = 10'h3ff - 10'(k * 29);
      wr({REG_INDEX[START_COUNT+k], 2'h0}, {6'h01, v}, 4'h3);
      chk_resp(resp, RESP_OKAY);
      chk_val(32'(pulse), 32'h0000_0000);
      chk_val(32'(ef[k]), 32'(v));
      chk_val(32'(eb[k]), 32'(v) * GRAIN_BYTES);
      rd({REG_INDEX[START_COUNT+k], 2'h0});
      chk_val(data, 32'(v));
    end
    wr({REG_INDEX[START_COUNT], 2'h0}, 16'h0000, 4'h1);
    chk_val(32'(ef[0]), 32'h0000_0300);
    wr({REG_INDEX[START_COUNT], 2'h0}, 16'h0100, 4'h2);
    chk_val(32'(ef[0]), 32'h0000_0100);
    wr({REG_INDEX[0], 2'h0}, 16'h0455, 4'h1);
    chk_val(32'(pulse), 32'h0000_0000);
    wr(12'h000, 16'h0155, 4'hf);
    chk_resp(resp, RESP_SLVERR);
    chk_val(32'(pulse), 32'h0000_0000);
    rd(12'h454);
    chk_resp(resp, RESP_SLVERR);
    chk_val(data, 32'h0000_0000);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk_val(32'(sf[0]), 32'h0000_0000);
    chk_val(32'(ef[0]), 32'h0000_0000);
    wrap_up;
  end
endmodule
`default_nettype wire
